/* common/pcg_pkg.sv */
// Purpose: Constants and types for the peripheral clock gating block
// Assumes: One core clock, AXI4-Lite register access, 32-bit data
// Notes: Unit index 0..7 are ports A..H, then serial, sync serial, counters
//
// Contract
// - Set bit clocks unit, clear bit stops it
// - Access to unclocked unit returns bus fault
// - All gating bits reset to zero
// - Reserved gating bits read zero, ignore writes
// - Run, sleep, deep-sleep sets per power state
// - Sleep sets apply only with auto gating
// - Second register bits 7..0 gate ports H..A
// - First register bits 17,16 gate counters 1,0
// - First register bit 4 sync, 0 async serial
package pcg_pkg;

  localparam int AW = 12;
  localparam int NUNIT = 12;

  // Register byte offsets
  localparam logic [AW-1:0] OFS_RUN_CLK_CFG = 12'h060;
  localparam logic [AW-1:0] OFS_RUN_GATE1 = 12'h100;
  localparam logic [AW-1:0] OFS_RUN_GATE2 = 12'h108;
  localparam logic [AW-1:0] OFS_SLP_GATE1 = 12'h110;
  localparam logic [AW-1:0] OFS_SLP_GATE2 = 12'h118;
  localparam logic [AW-1:0] OFS_DSL_GATE1 = 12'h120;
  localparam logic [AW-1:0] OFS_DSL_GATE2 = 12'h128;
  localparam logic [AW-1:0] OFS_INT_STAT = 12'h200;
  localparam logic [AW-1:0] OFS_INT_MASK = 12'h204;
  localparam logic [AW-1:0] OFS_EN_STAT = 12'h208;
  localparam logic [AW-1:0] OFS_FAULT_INFO = 12'h20C;

  // Field positions
  localparam int BIT_GP_COUNTER1 = 17;
  localparam int BIT_GP_COUNTER0 = 16;
  localparam int BIT_SYNC_SERIAL0 = 4;
  localparam int BIT_ASYNC_SERIAL0 = 0;
  localparam int BIT_PORT_A = 0;
  localparam int NUM_PORTS = 8;
  localparam int BIT_AUTO_GATING = 0;
  localparam int BIT_EVT_RD_FAULT = 0;
  localparam int BIT_EVT_WR_FAULT = 1;

  // Writable masks; everything else is reserved and reads zero
  localparam logic [31:0] GATE1_WMASK = 32'h0003_0011;
  localparam logic [31:0] GATE2_WMASK = 32'h0000_00FF;
  localparam logic [31:0] CLK_CFG_WMASK = 32'h0000_0001;
  localparam logic [31:0] EVT_WMASK = 32'h0000_0003;

  // Reset values
  localparam logic [31:0] GATE_RST = 32'h0000_0000;
  localparam logic [31:0] CLK_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] EVT_RST = 32'h0000_0000;

  // Unit indices beyond the ports
  localparam int UNIT_ASYNC_SERIAL0 = 8;
  localparam int UNIT_SYNC_SERIAL0 = 9;
  localparam int UNIT_GP_COUNTER0 = 10;
  localparam int UNIT_GP_COUNTER1 = 11;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PCG_PWR_RUN,
    PCG_PWR_SLEEP,
    PCG_PWR_DEEP
  } pcg_pwr_t;

  // Peripheral access seen on the system bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [NUNIT-1:0] sel;
  } pcg_acc_t;

  // Last fault record
  typedef struct packed {
    logic write;
    logic [NUNIT-1:0] sel;
  } pcg_fault_t;

endpackage

/* hw/pcg_clk_gate.sv */
// Purpose: Glitch-free clock gate for one unit
// Assumes: Enable changes only just after rising edges of clk_in
// Notes: Latch is open in the low phase, so the gate opens/closes at a low
`timescale 1ns/1ps
module pcg_clk_gate import pcg_pkg::*; (
  // Clock
  input wire logic clk_in,
  // Control
  input wire logic enable,
  // Gated clock
  output logic clk_out
);

  logic en_lat;

  // Latch holds during high phase, so no runt pulse can escape
  always_latch begin
    if (!clk_in) begin
      en_lat <= enable;
    end
  end

  assign clk_out = clk_in & en_lat;

endmodule

/* hw/pcg_access_guard.sv */
// Purpose: Bus fault on access to an unclocked unit
// Assumes: Access select is one-hot per unit, valid for one cycle
// Notes: Fault answer is combinational; events are registered pulses
`timescale 1ns/1ps
module pcg_access_guard import pcg_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Access in
  input pcg_acc_t acc,
  input wire logic [NUNIT-1:0] unit_en,
  // Answer
  output logic acc_fault,
  // Events
  output logic rd_evt,
  output logic wr_evt,
  output pcg_fault_t fault_rec
);

  logic hit_off;

  assign hit_off = |(acc.sel & ~unit_en);
  assign acc_fault = acc.valid & hit_off;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_evt <= 1'b0;
      wr_evt <= 1'b0;
    end else begin
      rd_evt <= acc_fault & ~acc.write;
      wr_evt <= acc_fault & acc.write;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_rec <= '0;
    end else if (acc_fault) begin
      fault_rec.write <= acc.write;
      fault_rec.sel <= acc.sel;
    end
  end

endmodule

/* hw/pcg_top.sv */
// Purpose: Peripheral clock gating with run, sleep and deep-sleep sets
// Assumes: AXI4-Lite slave, one write and one read in flight
// Notes: Gate enables come from flops so the latch gates stay clean
`timescale 1ns/1ps
module pcg_top import pcg_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Power state from the core
  input pcg_pwr_t pwr_state,
  // Peripheral access check
  input pcg_acc_t periph_acc,
  output logic periph_fault,
  // Unit clocks and enables
  output logic [NUNIT-1:0] unit_clk,
  output logic [NUNIT-1:0] unit_en,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] run_gate1_r, run_port_gate_ctrl_r;
  logic [31:0] slp_gate1_r, sleep_port_gate_ctrl_r;
  logic [31:0] dsl_gate1_r, deepsleep_port_gate_ctrl_r;
  logic [31:0] run_clock_config_r;
  logic [31:0] int_stat_r, int_mask_r;
  logic [NUNIT-1:0] unit_en_r, unit_en_nxt;
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r, rresp_nxt;
  logic wr_go, wr_hit;
  logic rd_evt, wr_evt;
  pcg_fault_t fault_rec;

  // Byte-lane merge under a writable mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] strb,
                                        input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = ((old & ~lane) | (dat & lane)) & wmask;
  endfunction

  // Map a register pair onto the unit vector
  function automatic logic [NUNIT-1:0] units(input logic [31:0] g1,
                                             input logic [31:0] g2);
    logic [NUNIT-1:0] u;
    u = '0;
    u[NUM_PORTS-1:0] = g2[BIT_PORT_A +: NUM_PORTS];
    u[UNIT_ASYNC_SERIAL0] = g1[BIT_ASYNC_SERIAL0];
    u[UNIT_SYNC_SERIAL0] = g1[BIT_SYNC_SERIAL0];
    u[UNIT_GP_COUNTER0] = g1[BIT_GP_COUNTER0];
    u[UNIT_GP_COUNTER1] = g1[BIT_GP_COUNTER1];
    units = u;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Write channel

  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;

  always_comb begin
    case (awaddr_r)
      OFS_RUN_CLK_CFG, OFS_RUN_GATE1, OFS_RUN_GATE2, OFS_SLP_GATE1,
      OFS_SLP_GATE2, OFS_DSL_GATE1, OFS_DSL_GATE2, OFS_INT_STAT,
      OFS_INT_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= {awaddr[AW-1:2], 2'h0};
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  ////////////////////////////////////////////////////////////////////////
  // Gating registers; reserved bits are never stored

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_gate1_r <= GATE_RST;
      run_port_gate_ctrl_r <= GATE_RST;
      slp_gate1_r <= GATE_RST;
      sleep_port_gate_ctrl_r <= GATE_RST;
      dsl_gate1_r <= GATE_RST;
      deepsleep_port_gate_ctrl_r <= GATE_RST;
    end else if (wr_go) begin
      case (awaddr_r)
        OFS_RUN_GATE1: run_gate1_r <=
          merge(run_gate1_r, wdata_r, wstrb_r, GATE1_WMASK);
        OFS_RUN_GATE2: run_port_gate_ctrl_r <=
          merge(run_port_gate_ctrl_r, wdata_r, wstrb_r, GATE2_WMASK);
        OFS_SLP_GATE1: slp_gate1_r <=
          merge(slp_gate1_r, wdata_r, wstrb_r, GATE1_WMASK);
        OFS_SLP_GATE2: sleep_port_gate_ctrl_r <=
          merge(sleep_port_gate_ctrl_r, wdata_r, wstrb_r, GATE2_WMASK);
        OFS_DSL_GATE1: dsl_gate1_r <=
          merge(dsl_gate1_r, wdata_r, wstrb_r, GATE1_WMASK);
        OFS_DSL_GATE2: deepsleep_port_gate_ctrl_r <=
          merge(deepsleep_port_gate_ctrl_r, wdata_r, wstrb_r, GATE2_WMASK);
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_clock_config_r <= CLK_CFG_RST;
    end else if (wr_go && awaddr_r == OFS_RUN_CLK_CFG) begin
      run_clock_config_r <=
        merge(run_clock_config_r, wdata_r, wstrb_r, CLK_CFG_WMASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Set selection and gates

  // Without auto gating the run set stays in force while asleep
  always_comb begin
    unit_en_nxt = units(run_gate1_r, run_port_gate_ctrl_r);
    if (run_clock_config_r[BIT_AUTO_GATING]) begin
      case (pwr_state)
        PCG_PWR_SLEEP: unit_en_nxt =
          units(slp_gate1_r, sleep_port_gate_ctrl_r);
        PCG_PWR_DEEP: unit_en_nxt =
          units(dsl_gate1_r, deepsleep_port_gate_ctrl_r);
        default: unit_en_nxt = units(run_gate1_r, run_port_gate_ctrl_r);
      endcase
    end
  end

  // Registered so each gate enable moves only after a rising edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_en_r <= '0;
    end else begin
      unit_en_r <= unit_en_nxt;
    end
  end

  assign unit_en = unit_en_r;

  for (genvar i = 0; i < NUNIT; i++) begin : g_gate
    pcg_clk_gate u_gate (
      .clk_in(core_clk),
      .enable(unit_en_r[i]),
      .clk_out(unit_clk[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus fault check

  pcg_access_guard u_guard (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .acc(periph_acc),
    .unit_en(unit_en_r),
    .acc_fault(periph_fault),
    .rd_evt(rd_evt),
    .wr_evt(wr_evt),
    .fault_rec(fault_rec)
  );

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_r <= EVT_RST;
    end else begin
      int_stat_r <= ((wr_go && awaddr_r == OFS_INT_STAT) ?
                     (int_stat_r & ~merge(32'h0000_0000, wdata_r, wstrb_r, EVT_WMASK)) :
                     int_stat_r)
                    | (32'(rd_evt) << BIT_EVT_RD_FAULT)
                    | (32'(wr_evt) << BIT_EVT_WR_FAULT);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask_r <= EVT_RST;
    end else if (wr_go && awaddr_r == OFS_INT_MASK) begin
      int_mask_r <= merge(int_mask_r, wdata_r, wstrb_r, EVT_WMASK);
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  ////////////////////////////////////////////////////////////////////////
  // Read channel

  assign arready = !rvalid_r;

  always_comb begin
    rresp_nxt = RESP_OKAY;
    case ({araddr[AW-1:2], 2'h0})
      OFS_RUN_CLK_CFG: rdata_nxt = run_clock_config_r;
      OFS_RUN_GATE1: rdata_nxt = run_gate1_r;
      OFS_RUN_GATE2: rdata_nxt = run_port_gate_ctrl_r;
      OFS_SLP_GATE1: rdata_nxt = slp_gate1_r;
      OFS_SLP_GATE2: rdata_nxt = sleep_port_gate_ctrl_r;
      OFS_DSL_GATE1: rdata_nxt = dsl_gate1_r;
      OFS_DSL_GATE2: rdata_nxt = deepsleep_port_gate_ctrl_r;
      OFS_INT_STAT: rdata_nxt = int_stat_r;
      OFS_INT_MASK: rdata_nxt = int_mask_r;
      OFS_EN_STAT: rdata_nxt = 32'(unit_en_r);
      OFS_FAULT_INFO: rdata_nxt = 32'(fault_rec);
      default: begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

endmodule

/* tb/pcg_top_chk.sv */
// Purpose: Port checks for the clock gating block
// Assumes: One core clock, async active-low reset
// Notes: Gated clock pulses are counted in the bench, not here
`timescale 1ns/1ps
module pcg_top_chk import pcg_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Core side
  input wire pcg_pwr_t pwr_state,
  input wire pcg_acc_t periph_acc,
  input wire logic periph_fault,
  input wire logic [NUNIT-1:0] unit_en,
  input wire logic irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  pcg_pwr_t pwr_q_r;
  pcg_pwr_t pwr_q2_r;
  pcg_pwr_t pwr_q3_r;
  ////////////////////////////////////////
  // History, so an enable move can be traced to its cause
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q_r <= PCG_PWR_RUN;
      pwr_q2_r <= PCG_PWR_RUN;
      pwr_q3_r <= PCG_PWR_RUN;
    end else begin
      pwr_q_r <= pwr_state;
      pwr_q2_r <= pwr_q_r;
      pwr_q3_r <= pwr_q2_r;
    end
  end
  ////////////////////////////////////////
  property p_fault;
    periph_acc.valid |-> periph_fault == |(periph_acc.sel & ~unit_en);
  endproperty
  a_fault: assert property (p_fault) else $error("fault mismatch");
  property p_idle;
    !periph_acc.valid |-> !periph_fault;
  endproperty
  a_idle: assert property (p_idle) else $error("fault without access");
  property p_rst;
    $rose(rst_n) |-> unit_en == '0 && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_en;
    $changed(unit_en) |-> bvalid || $past(bvalid) || pwr_state != pwr_q_r
      || pwr_q_r != pwr_q2_r || pwr_q2_r != pwr_q3_r;
  endproperty
  a_en: assert property (p_en) else $error("enable moved without cause");
  property p_irq;
    $rose(irq) |-> bvalid || $past(bvalid) || $past(periph_fault, 2) || $past(periph_fault, 3);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without event");
  property p_rd;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("late read data");
  property p_wr;
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("late write response");
  property p_bh;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bh: assert property (p_bh) else $error("bresp dropped");
  property p_rh;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_rh: assert property (p_rh) else $error("rdata dropped");
endmodule

/* tb/pcg_top_tb.sv */
// Purpose: Self-checking bench for the clock gating block
// Assumes: Bench is the AXI4-Lite master and the core side
// Notes: Ready is read at the falling edge before the taking edge
`timescale 1ns/1ps
module pcg_top_tb import pcg_pkg::*;;
  logic core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, periph_fault, irq;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb, wr_strb;
  logic [2:0] awprot, arprot;
  logic [1:0] bresp, rresp, s;
  pcg_pwr_t pwr_state;
  pcg_acc_t periph_acc;
  logic [NUNIT-1:0] unit_clk, unit_en;
  int err_count, num_checks, cyc, rdy_lag;
  int clk_cnt [NUNIT];
  localparam logic [AW-1:0] GOFS [6] = '{OFS_RUN_GATE1, OFS_RUN_GATE2, OFS_SLP_GATE1,
    OFS_SLP_GATE2, OFS_DSL_GATE1, OFS_DSL_GATE2};
  localparam int BITS [4] = '{BIT_ASYNC_SERIAL0, BIT_SYNC_SERIAL0, BIT_GP_COUNTER0,
    BIT_GP_COUNTER1};

  pcg_top uut (.core_clk, .rst_n, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
    .rvalid, .rready, .rdata, .rresp, .pwr_state, .periph_acc, .periph_fault, .unit_clk,
    .unit_en, .irq);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // A runt pulse shows up as an extra count
  for (genvar g = 0; g < NUNIT; g++) begin : g_cnt
    always @(posedge unit_clk[g]) clk_cnt[g]++;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Ready raised only after rdy_lag cycles, so response hold gets exercised
  task automatic bwr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    int n;
    @(posedge core_clk);
    {awvalid, wvalid, bready, awaddr, wdata, wstrb} <= {2'b11, rdy_lag == 0, a, d, wr_strb};
    b_ok = 1'b0;
    n = 0;
    while (!b_ok) begin
      @(negedge core_clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid && bready;
      r = bresp;
      @(posedge core_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      n++;
      if (!b_ok && n >= rdy_lag) bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask
  task automatic brd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    int n;
    @(posedge core_clk);
    {arvalid, rready, araddr} <= {1'b1, rdy_lag == 0, a};
    r_ok = 1'b0;
    n = 0;
    while (!r_ok) begin
      @(negedge core_clk);
      ar_ok = arvalid && arready;
      r_ok = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge core_clk);
      if (ar_ok) arvalid <= 1'b0;
      n++;
      if (!r_ok && n >= rdy_lag) rready <= 1'b1;
    end
    rready <= 1'b0;
  endtask
  task automatic acc(input int k, input logic w, input logic e);
    @(posedge core_clk);
    periph_acc <= '{valid: 1'b1, write: w, sel: NUNIT'(1) << k};
    @(negedge core_clk);
    chk(32'(periph_fault), 32'(e), "fault");
    @(posedge core_clk);
    periph_acc <= '0;
  endtask
  task automatic en_chk(input logic [NUNIT-1:0] e);
    @(negedge core_clk);
    chk(32'(unit_en), 32'(e), "unit_en");
  endtask
  task automatic pset(input pcg_pwr_t p, input logic [NUNIT-1:0] e);
    @(posedge core_clk);
    pwr_state <= p;
    repeat (3) @(posedge core_clk);
    en_chk(e);
  endtask
  task automatic cnt_chk(input int k, input int e);
    int c;
    @(negedge core_clk);
    c = clk_cnt[k];
    repeat (10) @(negedge core_clk);
    chk(32'(clk_cnt[k] - c), 32'(e), "clock pulses");
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      brd(GOFS[i], v, s);
      chk(v, GATE_RST, "gate reset");
    end
    chk({irq, 19'h0, unit_en}, 32'h0, "en irq reset");
    brd(OFS_RUN_CLK_CFG, v, s);
    chk(v, CLK_CFG_RST, "cfg reset");
    cnt_chk(11, 0);
    $display("t_reset done");
  endtask
  task automatic t_fields;
    bwr(OFS_RUN_GATE1, 32'hFFFF_FFFF, s);
    chk(32'(s), 32'(RESP_OKAY), "bresp");
    brd(OFS_RUN_GATE1, v, s);
    chk(v, 32'h0003_0011, "gate1 bits");
    for (int i = 0; i < 8; i++) begin
      bwr(OFS_RUN_GATE2, 32'hFFFF_FF00 | (32'h1 << i), s);
      brd(OFS_RUN_GATE2, v, s);
      chk(v, 32'h1 << i, "gate2 bits");
      en_chk({4'hF, 8'h1 << i});
    end
    for (int j = 0; j < 4; j++) begin
      bwr(OFS_RUN_GATE1, 32'h1 << BITS[j], s);
      en_chk({4'h1 << j, 8'h80});
    end
    $display("t_fields done");
  endtask
  task automatic t_clock;
    bwr(OFS_RUN_GATE1, 32'h0, s);
    bwr(OFS_RUN_GATE2, 32'h5, s);
    for (int k = 0; k < 4; k++) cnt_chk(k, k[0] ? 0 : 10);
    $display("t_clock done");
  endtask
  task automatic t_fault;
    bwr(OFS_RUN_GATE2, 32'h0, s);
    acc(3, 1'b0, 1'b1);
    acc(10, 1'b1, 1'b1);
    brd(OFS_INT_STAT, v, s);
    chk(v, 32'h3, "status");
    brd(OFS_FAULT_INFO, v, s);
    chk(v, 32'h0000_1400, "fault info");
    chk(32'(irq), 32'h0, "irq masked");
    bwr(OFS_INT_MASK, 32'h1, s);
    @(negedge core_clk);
    chk(32'(irq), 32'h1, "irq on");
    bwr(OFS_INT_STAT, 32'h1, s);
    @(negedge core_clk);
    chk(32'(irq), 32'h0, "irq off");
    brd(OFS_INT_STAT, v, s);
    chk(v, 32'h2, "w1c");
    bwr(OFS_INT_STAT, 32'h2, s);
    brd(OFS_RUN_GATE2, v, s);
    bwr(OFS_RUN_GATE2, v | 32'h8, s);
    acc(3, 1'b0, 1'b0);
    acc(3, 1'b1, 1'b0);
    brd(OFS_INT_STAT, v, s);
    chk(v, 32'h0, "no event");
    $display("t_fault done");
  endtask
  task automatic t_power;
    bwr(OFS_RUN_GATE2, 32'h1, s);
    bwr(OFS_SLP_GATE2, 32'h2, s);
    bwr(OFS_DSL_GATE2, 32'h4, s);
    pset(PCG_PWR_SLEEP, 12'h001);
    pset(PCG_PWR_DEEP, 12'h001);
    bwr(OFS_RUN_CLK_CFG, 32'h1, s);
    en_chk(12'h004);
    pset(PCG_PWR_SLEEP, 12'h002);
    pset(PCG_PWR_RUN, 12'h001);
    $display("t_power done");
  endtask
  task automatic t_bus;
    brd(12'h300, v, s);
    chk(v, 32'h0, "unmapped data");
    chk(32'(s), 32'(RESP_SLVERR), "unmapped resp");
    bwr(OFS_EN_STAT, 32'hFFF, s);
    chk(32'(s), 32'(RESP_SLVERR), "ro write");
    brd(OFS_EN_STAT, v, s);
    chk(v, 32'h1, "en stat");
    $display("t_bus done");
  endtask
  // Slow master and a single byte lane
  task automatic t_lag;
    rdy_lag = 3;
    wr_strb = 4'h4;
    bwr(OFS_RUN_GATE1, 32'h0003_0011, s);
    chk(32'(s), 32'(RESP_OKAY), "slow bresp");
    brd(OFS_RUN_GATE1, v, s);
    chk(v, 32'h0003_0000, "lane write");
    en_chk(12'hC01);
    rdy_lag = 0;
    wr_strb = 4'hF;
    $display("t_lag done");
  endtask
  ////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, awprot, arprot} = '0;
    pwr_state = PCG_PWR_RUN;
    periph_acc = '0;
    wr_strb = 4'hF;
    rdy_lag = 0;
    rst_n = 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_clock();
    t_fault();
    t_power();
    t_bus();
    t_lag();
    finish_test();
  end
endmodule

bind pcg_top pcg_top_chk u_chk (.core_clk, .rst_n, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp,
  .pwr_state, .periph_acc, .periph_fault, .unit_en, .irq);
